// >>> rtl/shb_pkg.sv
// constants, types and register map of the stream header builder
package shb_pkg;
  // register byte offsets
  localparam logic [7:0] SHB_A_CTRL = 8'h00;
  localparam logic [7:0] SHB_A_STAT = 8'h04;
  localparam logic [7:0] SHB_A_ETYPE = 8'h08;
  localparam logic [7:0] SHB_A_TPSEL = 8'h0C;
  localparam logic [7:0] SHB_A_DMACH = 8'h10;
  localparam logic [7:0] SHB_A_DMACL = 8'h14;
  localparam logic [7:0] SHB_A_SMACH = 8'h18;
  localparam logic [7:0] SHB_A_SMACL = 8'h1C;
  localparam logic [7:0] SHB_A_IPCFG = 8'h20;
  localparam logic [7:0] SHB_A_IPID = 8'h24;
  localparam logic [7:0] SHB_A_FRAG = 8'h28;
  localparam logic [7:0] SHB_A_PLEN = 8'h2C;
  localparam logic [7:0] SHB_A_SIP = 8'h30;
  localparam logic [7:0] SHB_A_DIP = 8'h34;
  localparam logic [7:0] SHB_A_GWIP = 8'h38;
  localparam logic [7:0] SHB_A_MASK = 8'h3C;
  localparam logic [7:0] SHB_A_TCI0 = 8'h40;
  localparam logic [7:0] SHB_A_TCI7 = 8'h5C;
  // control and fragment register bit positions
  localparam int SHB_C_START = 0;
  localparam int SHB_C_IDAUTO = 1;
  localparam int SHB_C_GWEN = 2;
  localparam int SHB_C_DHCP = 3;
  localparam int SHB_C_RLINK = 4;
  localparam int SHB_C_RNOW = 5;
  localparam int SHB_C_LLC = 6;
  localparam int SHB_C_SNAP = 7;
  localparam int SHB_C_CTL16 = 8;
  localparam int SHB_C_L3 = 9;
  localparam int SHB_C_VCNT = 11;
  localparam int SHB_F_MF = 13;
  localparam int SHB_F_DF = 14;
  // layer-3 selection codes
  localparam logic [1:0] SHB_L3_NONE = 2'h0;
  localparam logic [1:0] SHB_L3_IP4 = 2'h1;
  localparam logic [1:0] SHB_L3_IP6 = 2'h2;
  // header field values
  localparam logic [15:0] SHB_TP_8100 = 16'h8100;
  localparam logic [15:0] SHB_TP_88A8 = 16'h88A8;
  localparam logic [15:0] SHB_TP_9100 = 16'h9100;
  localparam logic [15:0] SHB_TP_9200 = 16'h9200;
  localparam logic [15:0] SHB_ET_IP4 = 16'h0800;
  localparam logic [15:0] SHB_ET_IP6 = 16'h86DD;
  localparam logic [15:0] SHB_ET_MIN = 16'h05DD;
  localparam logic [7:0] SHB_VER_IHL = 8'h45;
  localparam logic [15:0] SHB_IP4_HLEN = 16'h0014;
  localparam logic [7:0] SHB_SAP_SNAP = 8'hAA;
  localparam logic [7:0] SHB_SAP_IP = 8'h06;
  localparam logic [7:0] SHB_SAP_DEF = 8'h42;
  localparam logic [7:0] SHB_CTL_UI = 8'h03;
  localparam logic [23:0] SHB_SNAP_PID = 24'h000000;
  // segment lengths in bytes
  localparam logic [4:0] SHB_L_MAC = 5'h06;
  localparam logic [4:0] SHB_L_VLAN = 5'h04;
  localparam logic [4:0] SHB_L_TYPE = 5'h02;
  localparam logic [4:0] SHB_L_LLC = 5'h03;
  localparam logic [4:0] SHB_L_SNAP = 5'h05;
  localparam logic [4:0] SHB_L_IP4 = 5'h14;
  localparam int SHB_MAX_HDR = 75;
  // reset values and vlan level limit
  localparam logic [15:0] SHB_R_ETYPE = 16'hFFFF;
  localparam logic [7:0] SHB_R_TTL = 8'h20;
  localparam logic [31:0] SHB_R_MASK = 32'hFFFFFF00;
  localparam logic [3:0] SHB_VMAX = 4'h8;

  typedef enum logic [3:0] {
    SHB_IDLE = 4'h1, SHB_RES = 4'h2, SHB_BUILD = 4'h4, SHB_SEND = 4'h8
  } shb_state_t;

  typedef enum logic [6:0] {
    SHB_S_DMAC = 7'h01, SHB_S_SMAC = 7'h02, SHB_S_VLAN = 7'h04, SHB_S_TYPE = 7'h08,
    SHB_S_LLC = 7'h10, SHB_S_SNAP = 7'h20, SHB_S_IP4 = 7'h40
  } shb_seg_t;

  typedef struct packed {
    logic id_auto, gw_en, dhcp_en, renew_link, llc_en, snap_en, ctl16;
    logic [1:0] l3;
    logic [3:0] vcnt;
    logic [15:0] etype, tpsel;
    logic [47:0] dmac, smac;
    logic [7:0] dscp, ttl, proto;
    logic [12:0] frag;
    logic mf, df;
    logic [15:0] plen;
    logic [31:0] sip, dip, gwip, mask;
  } shb_cfg_t;

  // one memory write
  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } shb_wr_t;
endpackage : shb_pkg

// >>> rtl/shb_hdr_mem.sv
// header byte store with registered read data
`timescale 1ns/1ns
module shb_hdr_mem import shb_pkg::*; #(
  parameter int W = 8,
  parameter int DEPTH = 128
) (
  input wire logic clk,
  input wire shb_wr_t wr,
  input wire logic rd_en,
  input wire logic [6:0] rd_addr,
  output logic [W-1:0] rd_data
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0] q;
  } shb_mem_st_t;
  shb_mem_st_t s_reg, s_next;

  if (W != 8 || DEPTH < SHB_MAX_HDR || DEPTH > 128) begin : g_chk
    $error("shb_hdr_mem: unsupported size");
  end

  // write port and read register
  always_comb begin
    s_next = s_reg;
    if (wr.en) begin
      s_next.mem[wr.addr] = wr.data;
    end
    if (rd_en) begin
      s_next.q = s_reg.mem[rd_addr];
    end
  end

  always_ff @(posedge clk) begin
    s_reg <= s_next;
  end

  assign rd_data = s_reg.q;
endmodule : shb_hdr_mem

// >>> rtl/shb_top.sv
// stream header builder: register file, header assembly and byte output
// Notes on behaviour
// - outer vlan tpid picks among four values when two or more levels are set
// - inner type follows ipv4 or ipv6 automatically
// - programmed type accepted from 05DD to FFFF
// - llc saps filled from upper layer, control 03 or 16-bit zero
// - snap pid zero, type from upper layer
// - snap only emitted together with llc
// - ipv4 version 4, header length 5
// - auto increment gives new id per frame
// - enabled flags set, reserved flag zero
// - protocol field carries upper protocol number
// - ttl holds remaining hop count
// - total length computed from header and payload
// - off-net destination uses gateway lookup mac
// - mask is contiguous ones from msb
// - dhcp lease replaces programmed source address
// - renew lease on link re-establish
// - manual renew requests lease at once
// - each vlan level adds tci and type
`timescale 1ns/1ns
module shb_top import shb_pkg::*; #(
  parameter int DEPTH = 128
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic LINK_UP,
  output logic DHCP_RENEW,
  input wire logic DHCP_LEASE_VALID,
  input wire logic [31:0] DHCP_LEASE_IP,
  output logic LKP_REQ,
  output logic [31:0] LKP_IP,
  input wire logic LKP_ACK,
  input wire logic [47:0] LKP_MAC,
  output logic TX_VALID,
  input wire logic TX_READY,
  output logic [7:0] TX_DATA,
  output logic TX_LAST
);
  typedef struct packed {
    shb_cfg_t cfg;
    logic [7:0][15:0] tci;
    logic [15:0] ip_id;
    logic [31:0] lease_ip;
    logic lease_ok;
    logic [47:0] dst_mac;
    logic use_gw;
    shb_state_t st;
    shb_seg_t seg;
    logic [4:0] sub;
    logic [2:0] lvl;
    logic [6:0] wptr, rptr;
    logic out_valid, out_last, renew;
    logic link_s1, link_s2, link_d;
    logic [31:0] rdata;
  } shb_st_t;

  shb_st_t s_reg, s_next;
  shb_wr_t wr;
  logic rd_en;
  logic [31:0] sip;
  logic [15:0] tot_len, up_type, csum;
  logic [159:0] ip_hdr;
  logic off_net, start, fin;

  if (DEPTH < SHB_MAX_HDR || DEPTH > 128) begin : g_chk
    $error("shb_top: DEPTH cannot hold a full header");
  end

  function automatic logic [15:0] tpid(input logic [1:0] sel);
    unique case (sel)
      2'h0: tpid = SHB_TP_8100;
      2'h1: tpid = SHB_TP_88A8;
      2'h2: tpid = SHB_TP_9100;
      default: tpid = SHB_TP_9200;
    endcase
  endfunction : tpid

  // ones from msb: the inverse must be of the form 0..01..1
  function automatic logic contig(input logic [31:0] m);
    contig = (((~m) + 32'h1) & (~m)) == 32'h0;
  endfunction : contig

  // complement of the one's complement sum of header words with checksum as zero
  function automatic logic [15:0] ip_sum(input logic [159:0] h);
    logic [31:0] acc;
    acc = 32'h0;
    for (int i = 0; i < 10; i++) begin
      acc = acc + {16'h0, h[i*16 +: 16]};
    end
    acc = {16'h0, acc[15:0]} + {16'h0, acc[31:16]};
    acc = {16'h0, acc[15:0]} + {16'h0, acc[31:16]};
    ip_sum = ~acc[15:0];
  endfunction : ip_sum

  // derived header fields
  always_comb begin
    sip = s_reg.cfg.dhcp_en ? s_reg.lease_ip : s_reg.cfg.sip;
    tot_len = SHB_IP4_HLEN + s_reg.cfg.plen;
    unique case (s_reg.cfg.l3)
      SHB_L3_IP4: up_type = SHB_ET_IP4;
      SHB_L3_IP6: up_type = SHB_ET_IP6;
      default: up_type = s_reg.cfg.etype;
    endcase
    // judged at the starting write, so gateway and dhcp enables come from it
    off_net = WDATA[SHB_C_GWEN]
            && (((s_reg.cfg.dip ^ (WDATA[SHB_C_DHCP] ? s_reg.lease_ip : s_reg.cfg.sip))
                 & s_reg.cfg.mask) != 32'h0);
    ip_hdr = {SHB_VER_IHL, s_reg.cfg.dscp, tot_len, s_reg.ip_id,
              1'b0, s_reg.cfg.df, s_reg.cfg.mf, s_reg.cfg.frag,
              s_reg.cfg.ttl, s_reg.cfg.proto, 16'h0, sip, s_reg.cfg.dip};
    csum = ip_sum(ip_hdr);
    ip_hdr[79:64] = csum;
  end

  assign start = WR && ADDR == SHB_A_CTRL && WDATA[SHB_C_START] && s_reg.st == SHB_IDLE;
  assign rd_en = s_reg.st == SHB_SEND && s_reg.rptr < s_reg.wptr && (!s_reg.out_valid || TX_READY);
  assign fin = s_reg.st == SHB_SEND && s_reg.out_valid && TX_READY && s_reg.out_last;

  // next state: bus, dhcp, lookup, header assembly and output
  always_comb begin
    logic [4:0] slen;
    logic [7:0] b;
    logic [15:0] llen;
    logic last_b;
    logic [39:0] seg_w;
    s_next = s_reg;
    slen = SHB_L_MAC;
    b = 8'h00;
    llen = 16'h0;
    last_b = 1'b0;
    seg_w = 40'h0;
    wr = '0;
    s_next.rdata = 32'h0;
    s_next.renew = 1'b0;
    s_next.link_s1 = LINK_UP;
    s_next.link_s2 = s_reg.link_s1;
    s_next.link_d = s_reg.link_s2;
    // register writes
    if (WR) begin
      unique case (ADDR)
        SHB_A_CTRL: begin
          {s_next.cfg.ctl16, s_next.cfg.snap_en, s_next.cfg.llc_en} = WDATA[8:6];
          {s_next.cfg.renew_link, s_next.cfg.dhcp_en} = WDATA[4:3];
          {s_next.cfg.gw_en, s_next.cfg.id_auto} = WDATA[2:1];
          s_next.cfg.l3 = WDATA[SHB_C_L3 +: 2];
          s_next.cfg.vcnt = (WDATA[SHB_C_VCNT +: 4] > SHB_VMAX) ? SHB_VMAX
                          : WDATA[SHB_C_VCNT +: 4];
          s_next.renew = WDATA[SHB_C_RNOW];
        end
        SHB_A_ETYPE: begin
          if (WDATA[15:0] >= SHB_ET_MIN) begin
            s_next.cfg.etype = WDATA[15:0];
          end
        end
        SHB_A_TPSEL: s_next.cfg.tpsel = WDATA[15:0];
        SHB_A_DMACH: s_next.cfg.dmac[47:32] = WDATA[15:0];
        SHB_A_DMACL: s_next.cfg.dmac[31:0] = WDATA;
        SHB_A_SMACH: s_next.cfg.smac[47:32] = WDATA[15:0];
        SHB_A_SMACL: s_next.cfg.smac[31:0] = WDATA;
        SHB_A_IPCFG: {s_next.cfg.proto, s_next.cfg.ttl, s_next.cfg.dscp} = WDATA[23:0];
        SHB_A_IPID: s_next.ip_id = WDATA[15:0];
        SHB_A_FRAG: {s_next.cfg.df, s_next.cfg.mf, s_next.cfg.frag} = WDATA[14:0];
        SHB_A_PLEN: s_next.cfg.plen = WDATA[15:0];
        SHB_A_SIP: s_next.cfg.sip = WDATA;
        SHB_A_DIP: s_next.cfg.dip = WDATA;
        SHB_A_GWIP: s_next.cfg.gwip = WDATA;
        SHB_A_MASK: begin
          if (contig(WDATA)) begin
            s_next.cfg.mask = WDATA;
          end
        end
        default: begin
          if (ADDR >= SHB_A_TCI0 && ADDR <= SHB_A_TCI7 && ADDR[1:0] == 2'h0) begin
            s_next.tci[ADDR[4:2]] = WDATA[15:0];
          end
        end
      endcase
    end
    // register reads, answered in the next cycle
    if (RD) begin
      unique case (ADDR)
        SHB_A_CTRL: s_next.rdata = {17'h0, s_reg.cfg.vcnt, s_reg.cfg.l3, s_reg.cfg.ctl16,
                                    s_reg.cfg.snap_en, s_reg.cfg.llc_en, 1'b0,
                                    s_reg.cfg.renew_link, s_reg.cfg.dhcp_en,
                                    s_reg.cfg.gw_en, s_reg.cfg.id_auto, 1'b0};
        SHB_A_STAT: s_next.rdata = {24'h0, s_reg.st, s_reg.use_gw, s_reg.lease_ok,
                                    LKP_REQ, s_reg.st != SHB_IDLE};
        SHB_A_ETYPE: s_next.rdata = {16'h0, s_reg.cfg.etype};
        SHB_A_TPSEL: s_next.rdata = {16'h0, s_reg.cfg.tpsel};
        SHB_A_DMACH: s_next.rdata = {16'h0, s_reg.cfg.dmac[47:32]};
        SHB_A_DMACL: s_next.rdata = s_reg.cfg.dmac[31:0];
        SHB_A_SMACH: s_next.rdata = {16'h0, s_reg.cfg.smac[47:32]};
        SHB_A_SMACL: s_next.rdata = s_reg.cfg.smac[31:0];
        SHB_A_IPCFG: s_next.rdata = {8'h0, s_reg.cfg.proto, s_reg.cfg.ttl, s_reg.cfg.dscp};
        SHB_A_IPID: s_next.rdata = {16'h0, s_reg.ip_id};
        SHB_A_FRAG: s_next.rdata = {17'h0, s_reg.cfg.df, s_reg.cfg.mf, s_reg.cfg.frag};
        SHB_A_PLEN: s_next.rdata = {16'h0, s_reg.cfg.plen};
        SHB_A_SIP: s_next.rdata = sip;
        SHB_A_DIP: s_next.rdata = s_reg.cfg.dip;
        SHB_A_GWIP: s_next.rdata = s_reg.cfg.gwip;
        SHB_A_MASK: s_next.rdata = s_reg.cfg.mask;
        default: begin
          if (ADDR >= SHB_A_TCI0 && ADDR <= SHB_A_TCI7 && ADDR[1:0] == 2'h0) begin
            s_next.rdata = {16'h0, s_reg.tci[ADDR[4:2]]};
          end
        end
      endcase
    end
    // link comes back: ask for a fresh lease
    if (s_reg.cfg.renew_link && s_reg.link_s2 && !s_reg.link_d) begin
      s_next.renew = 1'b1;
    end
    // lease tracking, a new lease wins over a renew
    if (DHCP_LEASE_VALID) begin
      s_next.lease_ok = 1'b1;
      s_next.lease_ip = DHCP_LEASE_IP;
    end else if (s_reg.renew) begin
      s_next.lease_ok = 1'b0;
    end
    // frame sequencer
    unique case (s_reg.st)
      SHB_IDLE: begin
        if (start) begin
          s_next.st = off_net ? SHB_RES : SHB_BUILD;
          s_next.use_gw = off_net;
          s_next.dst_mac = s_reg.cfg.dmac;
          s_next.seg = SHB_S_DMAC;
          s_next.sub = 5'h0;
          s_next.lvl = 3'h0;
          s_next.wptr = 7'h0;
          s_next.rptr = 7'h0;
        end
      end
      SHB_RES: begin
        if (LKP_ACK) begin
          s_next.dst_mac = LKP_MAC;
          s_next.st = SHB_BUILD;
        end
      end
      SHB_BUILD: begin
        llen = {11'h0, SHB_L_LLC} + {15'h0, s_reg.cfg.ctl16 && !s_reg.cfg.snap_en}
             + (s_reg.cfg.snap_en ? {11'h0, SHB_L_SNAP} : 16'h0)
             + (s_reg.cfg.l3 == SHB_L3_IP4 ? tot_len : s_reg.cfg.plen);
        unique case (s_reg.seg)
          SHB_S_DMAC: b = s_reg.dst_mac[8'd47 - {s_reg.sub, 3'h0} -: 8];
          SHB_S_SMAC: b = s_reg.cfg.smac[8'd47 - {s_reg.sub, 3'h0} -: 8];
          SHB_S_VLAN: begin
            slen = SHB_L_VLAN;
            // a single level always uses the customer tag type
            seg_w[31:16] = SHB_TP_8100;
            if (s_reg.cfg.vcnt > 4'h1) begin
              seg_w[31:16] = tpid(s_reg.cfg.tpsel[{s_reg.lvl, 1'b0} +: 2]);
            end
            seg_w[15:0] = s_reg.tci[s_reg.lvl];
            b = seg_w[8'd31 - {s_reg.sub, 3'h0} -: 8];
          end
          SHB_S_TYPE: begin
            slen = SHB_L_TYPE;
            seg_w[15:0] = s_reg.cfg.llc_en ? llen : up_type;
            b = seg_w[8'd15 - {s_reg.sub, 3'h0} -: 8];
          end
          SHB_S_LLC: begin
            slen = SHB_L_LLC + {4'h0, s_reg.cfg.ctl16 && !s_reg.cfg.snap_en};
            if (s_reg.sub < 5'h2) begin
              b = s_reg.cfg.snap_en ? SHB_SAP_SNAP
                : (s_reg.cfg.l3 == SHB_L3_IP4 ? SHB_SAP_IP : SHB_SAP_DEF);
            end else begin
              b = (s_reg.sub == 5'h2 && slen == SHB_L_LLC) ? SHB_CTL_UI : 8'h00;
            end
          end
          SHB_S_SNAP: begin
            slen = SHB_L_SNAP;
            seg_w = {SHB_SNAP_PID, up_type};
            b = seg_w[8'd39 - {s_reg.sub, 3'h0} -: 8];
          end
          default: begin
            slen = SHB_L_IP4;
            b = ip_hdr[8'd159 - {s_reg.sub, 3'h0} -: 8];
          end
        endcase
        wr = '{en: 1'b1, addr: s_reg.wptr, data: b};
        s_next.wptr = s_reg.wptr + 7'h1;
        s_next.sub = s_reg.sub + 5'h1;
        if (s_reg.sub == slen - 5'h1) begin
          s_next.sub = 5'h0;
          unique case (s_reg.seg)
            SHB_S_DMAC: s_next.seg = SHB_S_SMAC;
            SHB_S_SMAC: s_next.seg = (s_reg.cfg.vcnt != 4'h0) ? SHB_S_VLAN : SHB_S_TYPE;
            SHB_S_VLAN: begin
              s_next.lvl = s_reg.lvl + 3'h1;
              if ({1'b0, s_reg.lvl} == s_reg.cfg.vcnt - 4'h1) begin
                s_next.seg = SHB_S_TYPE;
              end
            end
            SHB_S_TYPE: begin
              s_next.seg = s_reg.cfg.llc_en ? SHB_S_LLC : SHB_S_IP4;
              last_b = !s_reg.cfg.llc_en && s_reg.cfg.l3 != SHB_L3_IP4;
            end
            SHB_S_LLC: begin
              s_next.seg = s_reg.cfg.snap_en ? SHB_S_SNAP : SHB_S_IP4;
              last_b = !s_reg.cfg.snap_en && s_reg.cfg.l3 != SHB_L3_IP4;
            end
            SHB_S_SNAP: begin
              s_next.seg = SHB_S_IP4;
              last_b = s_reg.cfg.l3 != SHB_L3_IP4;
            end
            default: last_b = 1'b1;
          endcase
          if (last_b) begin
            s_next.st = SHB_SEND;
          end
        end
      end
      SHB_SEND: begin
        if (rd_en) begin
          s_next.rptr = s_reg.rptr + 7'h1;
          s_next.out_valid = 1'b1;
          s_next.out_last = s_reg.rptr == s_reg.wptr - 7'h1;
        end else if (TX_READY) begin
          s_next.out_valid = 1'b0;
        end
        if (fin) begin
          s_next.st = SHB_IDLE;
          if (s_reg.cfg.id_auto) begin
            s_next.ip_id = s_reg.ip_id + 16'h1;
          end
        end
      end
    endcase
    if (SRST) begin
      s_next = '0;
      s_next.st = SHB_IDLE;
      s_next.seg = SHB_S_DMAC;
      s_next.cfg.etype = SHB_R_ETYPE;
      s_next.cfg.ttl = SHB_R_TTL;
      s_next.cfg.mask = SHB_R_MASK;
      // link taken as up, so a link already up at reset is no false return
      s_next.link_s1 = 1'b1;
      s_next.link_s2 = 1'b1;
      s_next.link_d = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    s_reg <= s_next;
  end

  shb_hdr_mem #(.W(8), .DEPTH(DEPTH)) u_mem (
    .clk(CLK),
    .wr(wr),
    .rd_en(rd_en),
    .rd_addr(s_reg.rptr),
    .rd_data(TX_DATA)
  );

  // outputs
  assign RDATA = s_reg.rdata;
  assign DHCP_RENEW = s_reg.renew;
  assign LKP_REQ = s_reg.st == SHB_RES;
  assign LKP_IP = s_reg.cfg.gwip;
  assign TX_VALID = s_reg.out_valid;
  assign TX_LAST = s_reg.out_last;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence start_off_s;
    start && off_net;
  endsequence
  sequence wr_ip_s(int k);
    wr.en && s_reg.seg == SHB_S_IP4 && s_reg.sub == k;
  endsequence
  sequence lkp_done_s;
    LKP_REQ && LKP_ACK;
  endsequence

  outer_tpid_a: assert property (wr.en && s_reg.seg == SHB_S_VLAN && s_reg.sub == 5'h0 |->
    wr.data inside {8'h81, 8'h88, 8'h91, 8'h92}) else $error("bad outer tpid");
  auto_type_a: assert property (wr.en && s_reg.seg == SHB_S_TYPE && s_reg.sub == 5'h0
    && !s_reg.cfg.llc_en && s_reg.cfg.l3 == SHB_L3_IP4 |-> wr.data == 8'h08 ##1 wr.data == 8'h00)
    else $error("type not ipv4");
  etype_range_a: assert property (s_reg.cfg.etype >= SHB_ET_MIN) else $error("type below 05DD");
  snap_llc_a: assert property (s_reg.seg == SHB_S_SNAP && wr.en |-> s_reg.cfg.llc_en)
    else $error("snap without llc");
  ver_ihl_a: assert property (wr_ip_s(0) |-> wr.data == SHB_VER_IHL) else $error("bad ver ihl");
  res_flag_a: assert property (wr_ip_s(6) |-> wr.data[7] == 1'b0
    && wr.data[6:5] == {s_reg.cfg.df, s_reg.cfg.mf}) else $error("bad flags");
  tot_len_a: assert property (wr_ip_s(2) |-> wr.data == tot_len[15:8] ##1
    wr.data == 8'(s_reg.cfg.plen + 16'h14)) else $error("bad total length");
  id_step_a: assert property (fin && s_reg.cfg.id_auto && !(WR && ADDR == SHB_A_IPID) |=>
    s_reg.ip_id == $past(s_reg.ip_id) + 16'h1) else $error("id not stepped");
  gw_req_a: assert property (start_off_s |=> LKP_REQ && LKP_IP == s_reg.cfg.gwip)
    else $error("no gateway lookup");
  gw_mac_a: assert property (lkp_done_s |=> !LKP_REQ
    && s_reg.dst_mac == $past(LKP_MAC)) else $error("lookup mac not taken");
  mask_ok_a: assert property (contig(s_reg.cfg.mask)) else $error("mask not contiguous");
  renew_link_a: assert property (s_reg.cfg.renew_link && s_reg.link_s2 && !s_reg.link_d
    |=> DHCP_RENEW) else $error("no renew on link");
  renew_now_a: assert property (WR && ADDR == SHB_A_CTRL && WDATA[SHB_C_RNOW] |=> DHCP_RENEW)
    else $error("no manual renew");
endmodule : shb_top

// >>> test/shb_peer.sv
// far side model: dhcp engine, address lookup responder and frame sink
`timescale 1ns/1ns
module shb_peer #(
  parameter logic [47:0] GW_MAC = 48'h02AABBCCDDEE,
  parameter logic [31:0] LEASE = 32'h0A000005
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic dhcp_renew,
  output logic lease_valid,
  output logic [31:0] lease_ip,
  input wire logic lkp_req,
  output logic lkp_ack,
  output logic [47:0] lkp_mac,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_last
);
  logic [7:0] frame [0:127];
  int nb, nbytes, nfr, renews;
  logic [2:0] lk_cnt, dh_cnt;
  // ready every other cycle, lookup after four cycles, lease three after renew
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_ready <= 1'b0;
      lkp_ack <= 1'b0;
      lkp_mac <= 48'h0;
      lease_valid <= 1'b0;
      lease_ip <= 32'h0;
      {nb, nbytes, nfr, renews, lk_cnt, dh_cnt} <= '0;
    end else begin
      tx_ready <= ~tx_ready;
      if (tx_valid && tx_ready) begin
        frame[nb] <= tx_data;
        nb <= tx_last ? 0 : nb + 1;
        if (tx_last) begin
          nbytes <= nb + 1;
          nfr <= nfr + 1;
        end
      end
      lk_cnt <= (lkp_req && !lkp_ack) ? lk_cnt + 3'h1 : 3'h0;
      lkp_ack <= lkp_req && !lkp_ack && lk_cnt == 3'h3;
      lkp_mac <= (lkp_req && lk_cnt == 3'h3) ? GW_MAC : ~lkp_mac; // stale value garbled
      dh_cnt <= dhcp_renew ? 3'h1 : (dh_cnt != 3'h0 ? dh_cnt + 3'h1 : 3'h0);
      lease_valid <= dh_cnt == 3'h2;
      lease_ip <= dh_cnt == 3'h2 ? LEASE : ~lease_ip;
      renews <= renews + int'(dhcp_renew);
    end
  end
endmodule : shb_peer

// >>> test/tb.sv
// self-checking bench of the stream header builder
`timescale 1ns/1ns
module tb;
  import shb_pkg::*;
  logic CLK, SRST, WR, RD, LINK_UP, DHCP_RENEW, DHCP_LEASE_VALID, LKP_REQ, LKP_ACK;
  logic TX_VALID, TX_READY, TX_LAST;
  logic [7:0] ADDR, TX_DATA;
  logic [31:0] WDATA, RDATA, DHCP_LEASE_IP, LKP_IP, v;
  logic [47:0] LKP_MAC, id1;
  int mismatches = 0;
  int checked = 0;
  shb_top i_shb_top (.CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .LINK_UP(LINK_UP), .DHCP_RENEW(DHCP_RENEW),
    .DHCP_LEASE_VALID(DHCP_LEASE_VALID), .DHCP_LEASE_IP(DHCP_LEASE_IP), .LKP_REQ(LKP_REQ),
    .LKP_IP(LKP_IP), .LKP_ACK(LKP_ACK), .LKP_MAC(LKP_MAC), .TX_VALID(TX_VALID),
    .TX_READY(TX_READY), .TX_DATA(TX_DATA), .TX_LAST(TX_LAST));
  shb_peer i_shb_peer (.clk(CLK), .srst(SRST), .dhcp_renew(DHCP_RENEW),
    .lease_valid(DHCP_LEASE_VALID), .lease_ip(DHCP_LEASE_IP), .lkp_req(LKP_REQ),
    .lkp_ack(LKP_ACK), .lkp_mac(LKP_MAC), .tx_valid(TX_VALID), .tx_ready(TX_READY),
    .tx_data(TX_DATA), .tx_last(TX_LAST));
  task check(input string name, input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task print_verdict;
    if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask : rd
  // received bytes i .. i+n-1 as one big-endian value
  function automatic logic [47:0] fb(int i, int n);
    logic [47:0] r;
    r = 48'h0;
    for (int k = 0; k < n; k++) r = {r[39:0], i_shb_peer.frame[i + k]};
    return r;
  endfunction : fb
  // one's complement sum over the 20 header bytes at offset o
  function automatic logic [47:0] csum(int o);
    logic [31:0] s;
    s = 32'h0;
    for (int k = 0; k < 10; k++) s = s + fb(o + 2 * k, 2);
    s = s[15:0] + s[31:16];
    s = s[15:0] + s[31:16];
    return {32'h0, s[15:0]};
  endfunction : csum
  task send(input logic [31:0] ctrl, input int n);
    wr(SHB_A_CTRL, ctrl);
    for (int i = 0; i < 3000 && i_shb_peer.nfr < n; i++) @(posedge CLK);
    check("frame count", i_shb_peer.nfr, n);
  endtask : send
  task vlan_frame;
    check("dst mac", fb(0, 6), 48'h02AABBCCDDEE);
    check("outer tpid", fb(12, 2), 48'h88A8);
    check("inner tpid", fb(16, 2), 48'h8100);
    check("type", fb(20, 2), 48'h0800);
    check("ver ihl", fb(22, 1), 48'h45);
    check("total len", fb(24, 2), 48'h24);
    check("flags", fb(28, 2), 48'h4000);
    check("ttl", fb(30, 1), 48'h40);
    check("proto", fb(31, 1), 48'h06);
    check("checksum", csum(22), 48'hFFFF);
    check("bytes", i_shb_peer.nbytes, 42);
  endtask : vlan_frame
  // clock
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  // watchdog
  initial begin
    repeat (30000) @(posedge CLK);
    mismatches++;
    print_verdict;
  end
  // main sequence
  initial begin
    {SRST, WR, RD, ADDR, WDATA, LINK_UP} = {1'b1, 42'h0, 1'b1};
    repeat (4) @(posedge CLK);
    SRST <= 1'b0;
    rd(SHB_A_STAT, v);
    check("status idle", v, 32'h00000010);
    rd(SHB_A_IPCFG, v);
    check("ttl reset", v, 32'h00002000);
    wr(SHB_A_ETYPE, 32'h05DC);
    rd(SHB_A_ETYPE, v);
    check("etype low", v, 32'hFFFF);
    wr(SHB_A_ETYPE, 32'h05DD);
    rd(SHB_A_ETYPE, v);
    check("etype min", v, 32'h05DD);
    wr(SHB_A_MASK, 32'hFF00FF00);
    rd(SHB_A_MASK, v);
    check("mask", v, 32'hFFFFFF00);
    rd(8'hFC, v);
    check("unmapped", v, 32'h0);
    wr(SHB_A_TPSEL, 32'h1);
    wr(SHB_A_DMACH, 32'h0102);
    wr(SHB_A_DMACL, 32'h03040506);
    wr(SHB_A_IPCFG, 32'h00064000);
    wr(SHB_A_FRAG, 32'h4000);
    wr(SHB_A_PLEN, 32'h10);
    wr(SHB_A_SIP, 32'h0A000001);
    wr(SHB_A_DIP, 32'h0B000001);
    wr(SHB_A_GWIP, 32'h0A0000FE);
    send(32'h1207, 1);
    check("lookup ip", LKP_IP, 32'h0A0000FE);
    vlan_frame;
    id1 = fb(26, 2);
    send(32'h1207, 2);
    vlan_frame;
    check("id changes", 48'(fb(26, 2) !== id1), 48'h1);
    // a non-final fragment carries more-fragments
    wr(SHB_A_FRAG, 32'h2000);
    send(32'h02C1, 3);
    check("mf flag", fb(28, 2), 48'h2000);
    check("llc snap", fb(14, 6), 48'hAAAA03000000);
    check("snap type", fb(20, 2), 48'h0800);
    check("llc dsap", fb(12, 3), 48'h002CAA);
    check("llc csum", csum(22), 48'hFFFF);
    send(32'h0281, 4);
    check("no lone snap", fb(14, 1), 48'h45);
    check("no snap bytes", i_shb_peer.nbytes, 34);
    send(32'h0401, 5);
    check("ipv6 type", fb(12, 2), 48'h86DD);
    check("ipv6 bytes", i_shb_peer.nbytes, 14);
    send(32'h0001, 6);
    check("raw type", fb(12, 2), 48'h05DD);
    wr(SHB_A_CTRL, 32'h28);
    repeat (8) @(posedge CLK);
    check("renew now", i_shb_peer.renews, 1);
    rd(SHB_A_SIP, v);
    check("lease ip", v, 32'h0A000005);
    wr(SHB_A_CTRL, 32'h18);
    LINK_UP <= 1'b0;
    repeat (6) @(posedge CLK);
    LINK_UP <= 1'b1;
    repeat (10) @(posedge CLK);
    check("link renew", i_shb_peer.renews, 2);
    print_verdict;
  end
endmodule : tb
